// File: verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] CTRL_ZERO_OFS = 8'h00;
  localparam logic [7:0] CTRL_ONE_OFS = 8'h04;
  localparam logic [7:0] RESULT_HIGH_OFS = 8'h08;
  localparam logic [7:0] RESULT_LOW_OFS = 8'h0c;
  localparam logic [7:0] CTRL_TWO_OFS = 8'h10;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h14;

  // control zero fields
  localparam int ENABLE_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHAN_LSB = 2;
  localparam int CHAN_W = 5;

  // control one fields
  localparam int REF_LSB = 0;
  localparam int REF_W = 2;
  localparam int CLKSEL_LSB = 4;
  localparam int CLKSEL_W = 3;
  localparam int JUSTIFY_BIT = 7;

  // control two and status fields
  localparam int TRIG_LSB = 0;
  localparam int TRIG_W = 3;
  localparam int DONE_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;

  // reset values
  localparam logic [7:0] CTRL_ZERO_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [2:0] TRIG_RST = 3'h0;

  // trigger source codes
  localparam logic [2:0] TRIG_NONE = 3'h0;
  localparam logic [2:0] TRIG_CMP1 = 3'h1;
  localparam logic [2:0] TRIG_CMP2 = 3'h2;
  localparam logic [2:0] TRIG_TMR0 = 3'h3;
  localparam logic [2:0] TRIG_TMR1 = 3'h4;
  localparam logic [2:0] TRIG_TMR2 = 3'h5;

  // conversion clock codes; both low bits set means the rc clock
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [1:0] CLK_RC_LOW = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RC_TAD_NS = 1600;
  localparam int RC_HALF_CYCLES = RC_TAD_NS / (2 * CLK_PERIOD_NS);
  localparam int INSTR_CYCLE_NS = 40;
  localparam int INSTR_CYCLES =
    (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESULT_W = 10;
  // 11.5 bit periods counted in half periods
  localparam logic [4:0] CONV_HALVES = 5'd23;
  localparam logic [4:0] FIRST_RESOLVE_HALF = 5'd3;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONV
  } seq_state_t;

endpackage

// File: verilog/conv_tick_gen.sv
`timescale 1ns/1ps
module conv_tick_gen
  import adc_ctrl_pkg::*;
#(
  parameter int RC_HALF = RC_HALF_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  // one pulse per half bit period
  output logic tick_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tick_st_t;

  tick_st_t s_reg;
  tick_st_t s_next;
  logic [15:0] half_len;

  // half bit period length in system clocks
  always_comb begin
    unique case (sel_i)
      CLK_DIV2: half_len = 16'h0001;
      CLK_DIV4: half_len = 16'h0002;
      CLK_DIV8: half_len = 16'h0004;
      CLK_DIV16: half_len = 16'h0008;
      CLK_DIV32: half_len = 16'h0010;
      CLK_DIV64: half_len = 16'h0020;
      default: half_len = 16'(RC_HALF);
    endcase
  end

  // divider restarts whenever run drops
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run_i) begin
      s_next.cnt = 16'h0000;
    end else if (s_reg.cnt >= half_len - 16'h0001) begin
      s_next.cnt = 16'h0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_o = s_reg.tick;

endmodule

// File: verilog/adc_conv_ctrl.sv
`timescale 1ns/1ps
module adc_conv_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int RC_HALF = RC_HALF_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // trigger events, one-cycle pulses
  input wire logic trig_cmp1_i,
  input wire logic trig_cmp2_i,
  input wire logic trig_tmr0_i,
  input wire logic trig_tmr1_i,
  input wire logic trig_tmr2_i,
  // power state
  input wire logic sleep_i,
  output logic wake_o,
  output logic done_flag_o,
  // analog front end
  input wire logic comparator_i,
  output logic analog_enable_o,
  output logic hold_o,
  output logic [RESULT_W-1:0] dac_code_o,
  output logic [CHAN_W-1:0] channel_sel_o,
  output logic channel_valid_o,
  output logic [REF_W-1:0] ref_sel_o
);

  typedef struct packed {
    seq_state_t state;
    logic [7:0] ctrl_zero;
    logic [7:0] ctrl_one;
    logic [7:0] result_high;
    logic [7:0] result_low;
    logic [2:0] trig_sel;
    logic done_flag;
    logic irq_en;
    logic power_down;
    logic wake;
    logic [4:0] half_cnt;
    logic [3:0] bit_pos;
    logic last_bit;
    logic [RESULT_W-1:0] trial;
    logic [2:0] delay_cnt;
    logic ack;
    logic [31:0] rdata;
  } ctrl_st_t;

  ctrl_st_t s_reg;
  ctrl_st_t s_next;
  logic tick;
  logic run;

  // places a result into the two byte registers
  function automatic logic [15:0] pack_result(
    input logic [RESULT_W-1:0] code,
    input logic right
  );
    logic [15:0] r;
    r = 16'h0000;
    if (right) begin
      r = {6'h00, code};
    end else begin
      r[15:8] = code[9:2];
      r[7:6] = code[1:0];
    end
    return r;
  endfunction

  // fills bits 0 to pos with the last decided bit
  function automatic logic [RESULT_W-1:0] fill_partial(
    input logic [RESULT_W-1:0] code,
    input logic [3:0] pos,
    input logic lastb
  );
    logic [RESULT_W-1:0] r;
    r = code;
    for (int i = 0; i < RESULT_W; i++) begin
      if (4'(i) <= pos) begin
        r[i] = lastb;
      end
    end
    return r;
  endfunction

  // rc clock is any clock code with both low bits set
  function automatic logic is_rc(input logic [7:0] ctrl_one);
    return ctrl_one[CLKSEL_LSB +: 2] == CLK_RC_LOW;
  endfunction

  // conversion clock divider
  assign run = (s_reg.state == ST_CONV);

  conv_tick_gen #(
    .RC_HALF(RC_HALF)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .sel_i(s_reg.ctrl_one[CLKSEL_LSB +: CLKSEL_W]),
    .tick_o(tick)
  );

  // bus slave, register file and conversion sequencer
  always_comb begin
    logic bus_req;
    logic wr;
    logic busy;
    logic sw_go;
    logic sw_abort;
    logic trig_hit;
    logic start;
    logic rc;
    logic [15:0] packed_res;
    logic [RESULT_W-1:0] res;
    logic [7:0] wbyte;
    bus_req = 1'b0;
    wr = 1'b0;
    busy = 1'b0;
    sw_go = 1'b0;
    sw_abort = 1'b0;
    trig_hit = 1'b0;
    start = 1'b0;
    rc = 1'b0;
    packed_res = 16'h0000;
    res = '0;
    wbyte = 8'h00;
    s_next = s_reg;
    s_next.wake = 1'b0;

    // classic cycle: ack one cycle after the request, dropped after
    bus_req = cyc_i && stb_i;
    s_next.ack = bus_req && !s_reg.ack;
    wr = bus_req && we_i && s_reg.ack && sel_i[0];
    wbyte = dat_i[7:0];
    busy = (s_reg.state != ST_IDLE);
    rc = is_rc(s_reg.ctrl_one);

    // read data captured in the request cycle
    if (bus_req && !s_reg.ack) begin
      s_next.rdata = 32'h0000_0000;
      unique case (adr_i[7:0])
        CTRL_ZERO_OFS: s_next.rdata[7:0] = s_reg.ctrl_zero;
        CTRL_ONE_OFS: s_next.rdata[7:0] = s_reg.ctrl_one;
        RESULT_HIGH_OFS: s_next.rdata[7:0] = s_reg.result_high;
        RESULT_LOW_OFS: s_next.rdata[7:0] = s_reg.result_low;
        CTRL_TWO_OFS: s_next.rdata[TRIG_LSB +: TRIG_W] = s_reg.trig_sel;
        IRQ_STATUS_OFS: begin
          s_next.rdata[DONE_FLAG_BIT] = s_reg.done_flag;
          s_next.rdata[IRQ_EN_BIT] = s_reg.irq_en;
        end
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end

    // register writes; taken at the edge that sees ack
    if (wr) begin
      unique case (adr_i[7:0])
        CTRL_ZERO_OFS: begin
          s_next.ctrl_zero = {1'b0, wbyte[6:0]};
          s_next.ctrl_zero[GO_BIT] = s_reg.ctrl_zero[GO_BIT];
          sw_go = wbyte[GO_BIT] && wbyte[ENABLE_BIT];
          sw_abort = !wbyte[GO_BIT] && s_reg.ctrl_zero[GO_BIT];
        end
        CTRL_ONE_OFS: begin
          s_next.ctrl_one = {wbyte[7:4], 2'b00, wbyte[1:0]};
        end
        RESULT_HIGH_OFS: s_next.result_high = wbyte;
        RESULT_LOW_OFS: s_next.result_low = wbyte;
        CTRL_TWO_OFS: s_next.trig_sel = wbyte[TRIG_LSB +: TRIG_W];
        IRQ_STATUS_OFS: begin
          s_next.irq_en = wbyte[IRQ_EN_BIT];
          if (!wbyte[DONE_FLAG_BIT]) begin
            s_next.done_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // selected trigger source
    unique case (s_reg.trig_sel)
      TRIG_CMP1: trig_hit = trig_cmp1_i;
      TRIG_CMP2: trig_hit = trig_cmp2_i;
      TRIG_TMR0: trig_hit = trig_tmr0_i;
      TRIG_TMR1: trig_hit = trig_tmr1_i;
      TRIG_TMR2: trig_hit = trig_tmr2_i;
      default: trig_hit = 1'b0;
    endcase
    if (trig_hit && s_next.ctrl_zero[ENABLE_BIT] && !busy) begin
      sw_go = 1'b1;
    end

    // leaving sleep restores analog power
    if (!sleep_i) begin
      s_next.power_down = 1'b0;
    end

    // sequencer
    unique case (s_reg.state)
      ST_IDLE: begin
        if (sw_go && !(sleep_i && !rc)) begin
          start = 1'b1;
        end
      end
      ST_DELAY: begin
        if (sw_abort || !s_next.ctrl_zero[ENABLE_BIT]) begin
          s_next.ctrl_zero[GO_BIT] = 1'b0;
          s_next.state = ST_IDLE;
        end else if (s_reg.delay_cnt == 3'(INSTR_CYCLES - 1)) begin
          s_next.state = ST_CONV;
        end else begin
          s_next.delay_cnt = s_reg.delay_cnt + 3'h1;
        end
      end
      ST_CONV: begin
        if (sleep_i && !rc) begin
          // sleep on a system derived clock kills the conversion
          s_next.ctrl_zero[GO_BIT] = 1'b0;
          s_next.power_down = 1'b1;
          s_next.state = ST_IDLE;
        end else if (!s_next.ctrl_zero[ENABLE_BIT]) begin
          s_next.ctrl_zero[GO_BIT] = 1'b0;
          s_next.state = ST_IDLE;
        end else if (sw_abort) begin
          // partial result still lands in the byte registers
          res = fill_partial(s_reg.trial, s_reg.bit_pos,
                             s_reg.last_bit);
          packed_res = pack_result(res, s_reg.ctrl_one[JUSTIFY_BIT]);
          s_next.result_high = packed_res[15:8];
          s_next.result_low = packed_res[7:0];
          s_next.ctrl_zero[GO_BIT] = 1'b0;
          s_next.state = ST_IDLE;
        end else if (tick) begin
          if (s_reg.half_cnt == CONV_HALVES - 5'd1) begin
            packed_res = pack_result(s_reg.trial,
                                     s_reg.ctrl_one[JUSTIFY_BIT]);
            s_next.result_high = packed_res[15:8];
            s_next.result_low = packed_res[7:0];
            s_next.ctrl_zero[GO_BIT] = 1'b0;
            s_next.done_flag = 1'b1;
            s_next.state = ST_IDLE;
            if (sleep_i && rc) begin
              if (s_reg.irq_en) begin
                s_next.wake = 1'b1;
              end else begin
                s_next.power_down = 1'b1;
              end
            end
          end else begin
            s_next.half_cnt = s_reg.half_cnt + 5'd1;
            if (s_reg.half_cnt >= FIRST_RESOLVE_HALF &&
                s_reg.half_cnt[0]) begin
              // keep the trial bit only if the comparator agrees
              s_next.trial[s_reg.bit_pos] = comparator_i;
              s_next.last_bit = comparator_i;
              if (s_reg.bit_pos != 4'h0) begin
                s_next.trial[s_reg.bit_pos - 4'h1] = 1'b1;
              end
              s_next.bit_pos = s_reg.bit_pos - 4'h1;
            end
          end
        end
      end
      default: s_next.state = ST_IDLE;
    endcase

    // start of a conversion, hardware or software
    if (start) begin
      s_next.ctrl_zero[GO_BIT] = 1'b1;
      s_next.half_cnt = 5'd0;
      s_next.bit_pos = 4'(RESULT_W - 1);
      s_next.last_bit = 1'b0;
      s_next.trial = {1'b1, {(RESULT_W-1){1'b0}}};
      s_next.delay_cnt = 3'h0;
      s_next.power_down = 1'b0;
      s_next.state = rc ? ST_DELAY : ST_CONV;
    end
  end

  // state register; reset clears every register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.ctrl_zero <= CTRL_ZERO_RST;
      s_reg.ctrl_one <= CTRL_ONE_RST;
      s_reg.result_high <= RESULT_RST;
      s_reg.result_low <= RESULT_RST;
      s_reg.trig_sel <= TRIG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // bus and status outputs
  assign ack_o = s_reg.ack;
  assign dat_o = s_reg.rdata;
  assign wake_o = s_reg.wake;
  assign done_flag_o = s_reg.done_flag;

  // analog front end controls
  assign analog_enable_o =
    s_reg.ctrl_zero[ENABLE_BIT] && !s_reg.power_down;
  assign hold_o = (s_reg.state == ST_CONV);
  assign dac_code_o = s_reg.trial;
  assign channel_sel_o = s_reg.ctrl_zero[CHAN_LSB +: CHAN_W];
  assign ref_sel_o = s_reg.ctrl_one[REF_LSB +: REF_W];

  // reserved channel codes connect nothing
  always_comb begin
    logic [CHAN_W-1:0] c;
    c = s_reg.ctrl_zero[CHAN_LSB +: CHAN_W];
    channel_valid_o = (c <= 5'h04) || (c >= 5'h08 && c <= 5'h13) ||
      (c == 5'h1a) || (c == 5'h1b) || (c == 5'h1d) ||
      (c == 5'h1f);
  end

endmodule

// File: tb/adc_conv_ctrl_monitor.sv
`timescale 1ns/1ps
module adc_conv_ctrl_monitor
  import adc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int RC_HALF = RC_HALF_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // triggers and power
  input wire logic trig_cmp1_i,
  input wire logic trig_cmp2_i,
  input wire logic trig_tmr0_i,
  input wire logic trig_tmr1_i,
  input wire logic trig_tmr2_i,
  input wire logic sleep_i,
  input wire logic wake_o,
  input wire logic done_flag_o,
  // analog side
  input wire logic comparator_i,
  input wire logic analog_enable_o,
  input wire logic hold_o,
  input wire logic [RESULT_W-1:0] dac_code_o,
  input wire logic [CHAN_W-1:0] channel_sel_o,
  input wire logic channel_valid_o,
  input wire logic [REF_W-1:0] ref_sel_o
);
  // slowest divider, 23 halves of 32 clocks, plus margin
  localparam int MAX_HOLD = 800;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // codes that connect an input or a reference
  function automatic logic chan_ok(logic [4:0] c);
    return c <= 5'h04 || (c >= 5'h08 && c <= 5'h13) ||
      c == 5'h1a || c == 5'h1b || c == 5'h1d || c == 5'h1f;
  endfunction

  // request taken and start of a conversion
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_start;
    !hold_o ##1 hold_o;
  endsequence

  AST_ACK_ANSWER: assert property (s_req |=> ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  AST_RST_IDLE: assert property ($fell(rst_i) |-> !hold_o && !ack_o
    && dac_code_o == '0 && !analog_enable_o)
    else $error("outputs not idle after reset");
  AST_HOLD_POWER: assert property (hold_o |-> analog_enable_o)
    else $error("converting while powered down");
  AST_WAKE_COND: assert property (wake_o |-> $past(sleep_i)
    && done_flag_o && !hold_o)
    else $error("wake without a finished sleep conversion");
  AST_HOLD_BOUND: assert property (s_start |-> ##[1:MAX_HOLD] !hold_o)
    else $error("conversion did not end in time");
  AST_CHAN_DECODE: assert property (
    channel_valid_o == chan_ok(channel_sel_o))
    else $error("channel decode wrong");
endmodule

bind adc_conv_ctrl adc_conv_ctrl_monitor #(.ADDR_W(ADDR_W),
  .RC_HALF(RC_HALF)) i_adc_conv_ctrl_monitor (.*);

// File: tb/afe_model.sv
`timescale 1ns/1ps
module afe_model (
  // clock
  input wire logic clk_i,
  // converter side
  input wire logic powered_i,
  input wire logic hold_i,
  input wire logic [9:0] code_i,
  input wire logic [9:0] level_i,
  // decision back
  output logic comp_o
);
  logic flip_reg = 1'b0;

  // changing pattern while no sample is held
  always_ff @(posedge clk_i) begin
    flip_reg <= ~flip_reg;
  end

  // keep the trial bit while the held level reaches the code
  always_comb begin
    if (powered_i && hold_i) begin
      comp_o = level_i >= code_i;
    end else begin
      comp_o = flip_reg;
    end
  end
endmodule

// File: tb/adc_conv_ctrl_tb.sv
`timescale 1ns/1ps
module adc_conv_ctrl_tb
  import adc_ctrl_pkg::*;
;
  localparam int RCH = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [4:0] trig = 5'h00;
  wire trig_cmp1_i = trig[0];
  wire trig_cmp2_i = trig[1];
  wire trig_tmr0_i = trig[2];
  wire trig_tmr1_i = trig[3];
  wire trig_tmr2_i = trig[4];
  logic sleep_i = 1'b0;
  logic wake_o, done_flag_o, comparator_i, analog_enable_o;
  logic hold_o, channel_valid_o;
  logic [9:0] dac_code_o;
  logic [4:0] channel_sel_o;
  logic [1:0] ref_sel_o;
  logic [9:0] level = 10'h000;
  logic [31:0] q;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int hcnt = 0;

  adc_conv_ctrl #(.RC_HALF(RCH)) i_adc_conv_ctrl (.*);
  afe_model i_afe_model (.clk_i(clk_i), .powered_i(analog_enable_o),
    .hold_i(hold_o), .code_i(dac_code_o), .level_i(level),
    .comp_o(comparator_i));

  always #5 clk_i = ~clk_i;

  // hang ceiling and conversion length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (hold_o === 1'b1) hcnt <= hcnt + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // one classic cycle; q takes read data at the ack edge
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_idle();
    do bus(0, CTRL_ZERO_OFS, 8'h00); while (q[GO_BIT] !== 1'b0);
  endtask

  task automatic t_regs();
    bus(0, CTRL_ZERO_OFS, 8'h00);
    chk("ctrl_zero", 32'h0, q);
    chk("power", 0, analog_enable_o);
    bus(1, 8'h18, 8'hff);
    bus(0, 8'h18, 8'h00);
    chk("unmapped", 32'h0, q);
    bus(1, CTRL_ONE_OFS, 8'hff);
    bus(0, CTRL_ONE_OFS, 8'h00);
    chk("ctrl_one", 32'hf3, q);
    chk("ref", 3, ref_sel_o);
    sel_i <= 4'he;
    bus(1, CTRL_ONE_OFS, 8'h00);
    sel_i <= 4'hf;
    bus(0, CTRL_ONE_OFS, 8'h00);
    chk("masked write", 32'hf3, q);
    for (int c = 0; c < 32; c++) begin
      bus(1, CTRL_ZERO_OFS, {1'b0, c[4:0], 2'b00});
      chk("chan", c, channel_sel_o);
      chk("chan valid", c inside {[0:4], [8:19], 26, 27, 29, 31},
          channel_valid_o);
    end
  endtask

  task automatic t_conv(logic [2:0] c);
    logic [7:0] h;
    logic j;
    j = c[0];
    h = 8'd1 << (c[2] + 2 * c[1:0]);
    level = 10'h2c9 ^ {c, 7'h00};
    bus(1, CTRL_ONE_OFS, {j, c, 4'h0});
    bus(1, CTRL_ZERO_OFS, 8'h01);
    hcnt = 0;
    bus(1, CTRL_ZERO_OFS, 8'h03);
    wait_idle();
    if (c[1:0] != 2'h3) begin
      chk("hold len ok", 1, hcnt >= 22 * h && hcnt <= 24 * h + 1);
    end
    bus(0, RESULT_HIGH_OFS, 8'h00);
    chk("high", j ? {30'h0, level[9:8]} : {24'h0, level[9:2]}, q);
    bus(0, RESULT_LOW_OFS, 8'h00);
    chk("low", j ? {24'h0, level[7:0]} : {24'h0, level[1:0], 6'h0}, q);
    chk("done", 1, done_flag_o);
    bus(1, IRQ_STATUS_OFS, 8'h00);
    chk("done clear", 0, done_flag_o);
  endtask

  task automatic t_trig();
    logic [4:0] s;
    bus(1, CTRL_ONE_OFS, 8'h00);
    for (int k = 1; k <= 5; k++) begin
      s = 5'h01 << (k - 1);
      bus(1, CTRL_TWO_OFS, k[7:0]);
      trig <= 5'h1f ^ s;
      @(posedge clk_i);
      trig <= s;
      @(posedge clk_i);
      trig <= 5'h00;
      chk("other trig", 0, hold_o);
      @(posedge clk_i);
      chk("trig start", 1, hold_o);
      wait_idle();
      bus(1, IRQ_STATUS_OFS, 8'h00);
    end
    bus(1, CTRL_TWO_OFS, 8'h00);
  endtask

  task automatic t_sleep();
    bus(1, CTRL_ONE_OFS, 8'h30);
    bus(1, IRQ_STATUS_OFS, 8'h02);
    bus(1, CTRL_ZERO_OFS, 8'h03);
    chk("rc delay", 0, hold_o);
    sleep_i <= 1'b1;
    do @(posedge clk_i); while (wake_o !== 1'b1);
    sleep_i <= 1'b0;
    chk("wake done", 1, done_flag_o);
    bus(1, IRQ_STATUS_OFS, 8'h00);
    bus(1, CTRL_ZERO_OFS, 8'h03);
    sleep_i <= 1'b1;
    do @(posedge clk_i); while (done_flag_o !== 1'b1);
    chk("no wake", 0, wake_o);
    @(posedge clk_i);
    chk("rc off", 0, analog_enable_o);
    bus(0, CTRL_ZERO_OFS, 8'h00);
    chk("rc enable kept", 32'h1, q);
    sleep_i <= 1'b0;
    bus(1, CTRL_ONE_OFS, 8'h60);
    bus(1, IRQ_STATUS_OFS, 8'h00);
    bus(1, CTRL_ZERO_OFS, 8'h03);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    chk("sleep abort", 0, hold_o);
    chk("sleep off", 0, analog_enable_o);
    bus(0, CTRL_ZERO_OFS, 8'h00);
    chk("enable kept", 32'h1, q);
    sleep_i <= 1'b0;
  endtask

  task automatic t_abort();
    level = 10'h200;
    bus(1, CTRL_ONE_OFS, 8'he0);
    bus(1, CTRL_ZERO_OFS, 8'h03);
    do @(posedge clk_i); while (dac_code_o !== 10'h300);
    bus(1, CTRL_ZERO_OFS, 8'h01);
    bus(0, CTRL_ZERO_OFS, 8'h00);
    chk("abort go", 32'h1, q);
    bus(0, RESULT_HIGH_OFS, 8'h00);
    chk("partial high", 32'h3, q);
    bus(0, RESULT_LOW_OFS, 8'h00);
    chk("partial low", 32'hff, q);
    bus(1, CTRL_ZERO_OFS, 8'h03);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset hold", 0, hold_o);
    bus(0, CTRL_ONE_OFS, 8'h00);
    chk("reset ctrl_one", 32'h0, q);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    for (int c = 0; c < 8; c++) t_conv(c[2:0]);
    t_trig();
    t_sleep();
    t_abort();
    summarize();
  end
endmodule
